// *** rtl/drc_pkg.sv ***
package drc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_LANE_SYNC   = 8'h15;
   localparam logic [7:0] IDX_CFG_PRIMARY = 8'h20;
   localparam logic [7:0] IDX_CFG_SECOND  = 8'h21;
   localparam logic [7:0] IDX_ERR_CFG_1   = 8'h23;
   localparam logic [7:0] IDX_RX_STATUS   = 8'h28;
   localparam logic [7:0] IDX_INT_STATUS  = 8'h30;
   localparam logic [7:0] IDX_INT_MASK    = 8'h31;

   // Reset values
   localparam logic [7:0] RST_CFG_PRIMARY = 8'h7F;
   localparam logic [7:0] RST_CFG_SECOND  = 8'h00;
   localparam logic [7:0] RST_ERR_CFG_1   = 8'h7F;

   // Writable bit masks; everything else is reserved and reads zero
   localparam logic [7:0] WM_CFG_PRIMARY  = 8'h7F;
   localparam logic [7:0] WM_CFG_SECOND   = 8'hFB;
   localparam logic [7:0] WM_ERR_CFG_1    = 8'h7F;
   localparam logic [3:0] WM_INT          = 4'hF;

   // Field positions, primary configuration
   localparam int P_RECOVERY   = 6;
   localparam int P_IGNORE_CMD = 5;
   localparam int P_SYNC_REGEN = 4;
   // Field positions, secondary configuration
   localparam int P_NO_GRAY    = 7;
   localparam int P_VS_POL     = 6;
   localparam int P_HS_POL     = 5;
   localparam int P_HOLD_ERR   = 4;
   localparam int P_BLANK_CRC  = 3;
   localparam int P_NO_FILTER  = 1;
   localparam int P_NO_EOTPKT  = 0;
   // Error configuration and status fields
   localparam int P_CRC_EN     = 1;
   localparam int P_INV_VC_EN  = 3;
   localparam int P_EOT_ERR    = 2;
   localparam int P_ERR_DET    = 0;
   // Interrupt status bits
   localparam int I_SYNC  = 0;
   localparam int I_VC    = 1;
   localparam int I_EOT   = 2;
   localparam int I_CRC   = 3;

   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // Events and levels from the protocol logic; all but vs and hs sampled on link clock edges
   typedef struct packed {
      logic       sync_err;    // Synchronization error
      logic [3:0] lane_sync;   // Per-lane sync state
      logic       pkt_start;   // Packet header received
      logic [1:0] pkt_vc;      // Virtual channel of that packet
      logic       crc_err;     // Checksum error on long packet
      logic       blank_pkt;   // Packet is null or blanking
      logic       wc_bad;      // Word count out of range
      logic       hs_cmd;      // High-speed command received
      logic       eot;         // Transmission ended
      logic       eot_pkt;     // End packet was seen in it
      logic       vs;          // Raw vertical sync
      logic       hs;          // Raw horizontal sync
   } drc_link_type;
endpackage

// *** rtl/drc_regs.sv ***
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Lane sync bits captured at sync error
// - Recovery bit enables automatic error recovery
// - Command bit: process or ignore commands
// - Regeneration bit gates sync timing output
// - Channel enables flag invalid-channel packets
// - Invalid channel reaches summary only when enabled
// - Packets on disabled channels still pass
// - Grayscale replication unless disable bit set
// - Vertical sync polarity select
// - Horizontal sync polarity select
// - Hold bit: latched versus pulsed error
// - Bit three gates blank packet checksum errors
// - Disable bit turns off word-count filter
// - Missing end packet flagged unless skipped
// - End error at status bit two, read-clear
// - Invalid channel enable is error-config bit three
module drc_regs (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic [31:0]       hrdata,
   output logic              hresp,
   input  wire logic         link_clk,
   input  wire drc_pkg::drc_link_type link_in,
   input  wire logic [15:0]  pixel_in,
   output logic [23:0]       pixel_out,
   output logic              vsync_out,
   output logic              hsync_out,
   output logic              error_out,
   output logic              recover_req,
   output logic              cmd_accept,
   output logic              pkt_pass,
   output logic              pkt_drop,
   output logic              irq
);
   localparam int LW = $bits(drc_pkg::drc_link_type);

   // Block notes for the next engineer:
   // - All link fields are levels.
   // - They cross two flip-flops first.
   // - Only a link clock rise uses them, except vs and hs.
   // - Events last one hclk cycle.
   // - Sticky flags: event beats clear.
   // - Bus answers with no wait state.
   // - Read data in bits 7:0 only.
   // - Upper data bits read as zero.
   // - hsize is not decoded; words only.
   // - Unmapped reads return zero.
   // - Unmapped writes are dropped.
   // - Slave never answers with ERROR.
   // - Only one slave sits on the bus.

   // Register file
   logic [3:0]  lane0_3_snapshot;      // Lane sync snapshot
   logic [7:0]  cfg_primary;           // Recovery, commands, regen, channel enables
   logic [7:0]  cfg_second;            // Grayscale, polarities, hold, filters
   logic [7:0]  err_cfg;               // Error enables onto summary
   logic [7:0]  rx_status;             // Read-clear status
   logic [3:0]  int_status;            // Sticky interrupt events
   logic [3:0]  int_mask;              // Interrupt enables
   logic        hold_err;              // Latched error indication

   // AHB data phase capture
   logic        dp_write;              // Write pending in data phase
   logic [7:0]  dp_index;              // Its register index

   // Synchronisers: link clock and link bus
   logic [2:0]  clk_sync;              // Two stages plus edge history
   logic [LW-1:0] link_s1;             // First stage, read only by second
   logic [LW-1:0] link_s2;             // Second stage, safe to use
   drc_pkg::drc_link_type lk;          // Synchronised view

   // Index match; shared by every decode
   function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
      hit = (idx == want);
   endfunction

   // Address phase decode
   wire         addr_ok   = hsel && hready && (htrans == drc_pkg::HTRANS_NONSEQ);
   wire [7:0]   a_index   = (haddr[31:10] == 22'h000000) ? haddr[9:2] : 8'hFF;
   wire         rd_take   = addr_ok && !hwrite;
   wire         rd_status = rd_take && hit(a_index, drc_pkg::IDX_RX_STATUS);
   wire [7:0]   wd        = hwdata[7:0];

   // Link clock rising edge from its synchronised copy
   wire         link_edge = clk_sync[1] && !clk_sync[2];
   assign lk = drc_pkg::drc_link_type'(link_s2);

   // Event notes:
   // - Sync error always reaches summary.
   // - Invalid channel needs its enable.
   // - Checksum needs its own enable.
   // - Missing end packet never reaches summary.
   // - Blank checksum can be quieted.

   // Events, each one hclk cycle on a link clock edge
   wire         ev_sync   = link_edge && lk.sync_err;
   wire         vc_off    = !cfg_primary[lk.pkt_vc];
   wire         ev_vc     = link_edge && lk.pkt_start && vc_off;
   wire         crc_quiet = lk.blank_pkt && cfg_second[drc_pkg::P_BLANK_CRC];
   wire         ev_crc    = link_edge && lk.crc_err && !crc_quiet;
   wire         ev_eot    = link_edge && lk.eot && !lk.eot_pkt
                            && !cfg_second[drc_pkg::P_NO_EOTPKT];
   wire         ev_sum    = ev_sync || (ev_vc && err_cfg[drc_pkg::P_INV_VC_EN])
                            || (ev_crc && err_cfg[drc_pkg::P_CRC_EN]);
   wire         ev_any    = ev_sync || ev_vc || ev_crc || ev_eot;
   wire [3:0]   ev_vec    = {ev_crc, ev_eot, ev_vc, ev_sync};

   // Strobe notes:
   // - Index was saved at address edge.
   // - Data is read in the data phase.

   // Write strobes in the data phase
   wire         w_cfg0 = dp_write && hit(dp_index, drc_pkg::IDX_CFG_PRIMARY);
   wire         w_cfg1 = dp_write && hit(dp_index, drc_pkg::IDX_CFG_SECOND);
   wire         w_ecfg = dp_write && hit(dp_index, drc_pkg::IDX_ERR_CFG_1);
   wire         w_ist  = dp_write && hit(dp_index, drc_pkg::IDX_INT_STATUS);
   wire         w_imsk = dp_write && hit(dp_index, drc_pkg::IDX_INT_MASK);

   // Read notes:
   // - Lane snapshot is read-only.
   // - Interrupt words are four bits.
   // - Fall through gives zero.

   // Read mux, reserved bits zero
   wire [7:0]   rd_mux =
      hit(a_index, drc_pkg::IDX_LANE_SYNC)   ? {4'h0, lane0_3_snapshot} :
      hit(a_index, drc_pkg::IDX_CFG_PRIMARY) ? cfg_primary :
      hit(a_index, drc_pkg::IDX_CFG_SECOND)  ? cfg_second :
      hit(a_index, drc_pkg::IDX_ERR_CFG_1)   ? err_cfg :
      hit(a_index, drc_pkg::IDX_RX_STATUS)   ? rx_status :
      hit(a_index, drc_pkg::IDX_INT_STATUS)  ? {4'h0, int_status} :
      hit(a_index, drc_pkg::IDX_INT_MASK)    ? {4'h0, int_mask} : 8'h00;

   // Flag notes:
   // - Clear first, then OR in events.
   // - Hold level clears with status.

   // Next values for flags where a new event beats the clear
   wire [7:0]   next_rx_status = (rd_status ? 8'h00 : rx_status)
                                 | ({7'h00, ev_sum} << drc_pkg::P_ERR_DET)
                                 | ({7'h00, ev_eot} << drc_pkg::P_EOT_ERR);
   wire [3:0]   next_int_status = (w_ist ? (int_status & ~wd[3:0]) : int_status) | ev_vec;
   wire         next_hold_err = (rd_status ? 1'b0 : hold_err) || ev_sum;

   // Pixel notes:
   // - Input is five-six-five RGB.
   // - Top bits fill the low bits.
   // - Disabled: low bits are zero.
   // - Gives full white at full scale.

   // Grayscale expansion of 5-6-5 pixels
   wire [4:0]   px_r = pixel_in[15:11];
   wire [5:0]   px_g = pixel_in[10:5];
   wire [4:0]   px_b = pixel_in[4:0];
   wire         gray_on = !cfg_second[drc_pkg::P_NO_GRAY];
   wire [23:0]  next_pixel = gray_on ?
      {px_r, px_r[4:2], px_g, px_g[5:4], px_b, px_b[4:2]} :
      {px_r, 3'h0, px_g, 2'h0, px_b, 3'h0};

   // Polarity notes:
   // - One flips the incoming level.

   // Polarity applied so outputs are always active high
   wire         vs_norm = lk.vs ^ cfg_second[drc_pkg::P_VS_POL];
   wire         hs_norm = lk.hs ^ cfg_second[drc_pkg::P_HS_POL];

   // Synchroniser notes:
   // - Stage one may go metastable.
   // - Only stage two feeds logic.
   // - Third clock bit is history only.
   // - Edge seen three edges late.
   // - Link fields must stand longer
   //   than that delay around a rise.
   // - A link clock faster than about
   //   a third of hclk would alias.

   // Synchronisers; link signals are only trusted after two stages
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_sync <= 3'h0;
         link_s1  <= '0;
         link_s2  <= '0;
      end else begin
         clk_sync <= {clk_sync[1:0], link_clk};
         link_s1  <= link_in;
         link_s2  <= link_s1;
      end
   end

   // Bus timing notes:
   // - Address taken with hready high.
   // - Read data loaded at that edge.
   // - Write lands in the data phase.
   // - Back to back is fine, but a read just after a write to the same register sees the old value.
   // - A status read clears at the
   //   address edge, so a data phase
   //   that never comes still clears.

   // AHB slave: zero wait state, read data registered in address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h00000000;
         dp_write  <= 1'b0;
         dp_index  <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         dp_write  <= addr_ok && hwrite;
         dp_index  <= a_index;
         if (rd_take) begin
            hrdata <= {24'h000000, rd_mux};
         end
      end
   end

   // Configuration notes:
   // - Masks drop reserved bits.
   // - Only byte lane 0 is used.
   // - New values act one edge later.
   // - Channel enables only report.

   // Configuration registers; masks keep reserved bits at zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_primary <= drc_pkg::RST_CFG_PRIMARY;
         cfg_second  <= drc_pkg::RST_CFG_SECOND;
         err_cfg     <= drc_pkg::RST_ERR_CFG_1;
         int_mask    <= 4'h0;
      end else begin
         if (w_cfg0) cfg_primary <= wd & drc_pkg::WM_CFG_PRIMARY;
         if (w_cfg1) cfg_second  <= wd & drc_pkg::WM_CFG_SECOND;
         if (w_ecfg) err_cfg     <= wd & drc_pkg::WM_ERR_CFG_1;
         if (w_imsk) int_mask    <= wd[3:0] & drc_pkg::WM_INT;
      end
   end

   // Status notes:
   // - Snapshot moves only on sync error.
   // - Read-clear loses to a new event.
   // - W1C loses to a new event too.
   // - irq follows next status value,
   //   so it rises with the status bit.

   // Status, snapshot and interrupt state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lane0_3_snapshot <= 4'h0;
         rx_status        <= 8'h00;
         int_status       <= 4'h0;
         hold_err         <= 1'b0;
         irq              <= 1'b0;
      end else begin
         if (ev_sync) lane0_3_snapshot <= lk.lane_sync;
         rx_status  <= next_rx_status;
         int_status <= next_int_status;
         hold_err   <= next_hold_err;
         irq        <= |(next_int_status & int_mask);
      end
   end

   // Datapath notes:
   // - Pixel path is one flop deep.
   // - Sync outputs are active high.
   // - Polarity bits undo inversion.
   // - Pulses last one hclk cycle.
   // - A drop never comes with a pass.

   // Datapath outputs toward the rest of the receiver
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pixel_out   <= 24'h000000;
         vsync_out   <= 1'b0;
         hsync_out   <= 1'b0;
         error_out   <= 1'b0;
         recover_req <= 1'b0;
         cmd_accept  <= 1'b0;
         pkt_pass    <= 1'b0;
         pkt_drop    <= 1'b0;
      end else begin
         pixel_out   <= next_pixel;
         // Without regeneration the sync outputs stay idle
         vsync_out   <= cfg_primary[drc_pkg::P_SYNC_REGEN] && vs_norm;
         hsync_out   <= cfg_primary[drc_pkg::P_SYNC_REGEN] && hs_norm;
         // Held until the status is read, or a single pulse
         error_out   <= cfg_second[drc_pkg::P_HOLD_ERR] ? next_hold_err : ev_sum;
         recover_req <= ev_any && cfg_primary[drc_pkg::P_RECOVERY];
         cmd_accept  <= link_edge && lk.hs_cmd && !cfg_primary[drc_pkg::P_IGNORE_CMD];
         // Channel enables never discard; only the word count filter can
         pkt_pass    <= link_edge && lk.pkt_start
                        && !(lk.wc_bad && !cfg_second[drc_pkg::P_NO_FILTER]);
         pkt_drop    <= link_edge && lk.pkt_start && lk.wc_bad
                        && !cfg_second[drc_pkg::P_NO_FILTER];
      end
   end

   // Assertion notes:
   // - All run on hclk.
   // - All are off during reset.
   // - $past looks one edge back.
   // - Events come from link edges,
   //   so most checks are sparse.

   // Checks
   a_snap_capture: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_sync |=> lane0_3_snapshot == $past(lk.lane_sync))
      else $error("lane snapshot not captured");
   a_recover_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      recover_req |-> $past(cfg_primary[drc_pkg::P_RECOVERY]) && $past(ev_any))
      else $error("recovery request without enable");
   a_cmd_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
      cmd_accept |-> !$past(cfg_primary[drc_pkg::P_IGNORE_CMD]))
      else $error("command accepted while ignored");
   a_regen_off: assert property (@(posedge hclk) disable iff (!hresetn)
      !$past(cfg_primary[drc_pkg::P_SYNC_REGEN]) |-> !vsync_out && !hsync_out)
      else $error("sync out without regeneration");
   a_vc_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_vc |=> int_status[drc_pkg::I_VC])
      else $error("invalid channel not flagged");
   a_vc_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      (ev_vc && !ev_sync && !ev_crc && !err_cfg[drc_pkg::P_INV_VC_EN] && !rx_status[drc_pkg::P_ERR_DET])
      |=> !rx_status[drc_pkg::P_ERR_DET])
      else $error("invalid channel reached summary while disabled");
   a_vc_pass: assert property (@(posedge hclk) disable iff (!hresetn)
      (link_edge && lk.pkt_start && !lk.wc_bad) |=> pkt_pass)
      else $error("packet on disabled channel discarded");
   a_gray_fill: assert property (@(posedge hclk) disable iff (!hresetn)
      gray_on |=> pixel_out[18:16] == $past(pixel_in[15:13]))
      else $error("grayscale bits not replicated");
   a_hold_level: assert property (@(posedge hclk) disable iff (!hresetn)
      (cfg_second[drc_pkg::P_HOLD_ERR] && error_out && !rd_status && !w_cfg1) |=> error_out)
      else $error("held error dropped early");
   a_eot_flag: assert property (@(posedge hclk) disable iff (!hresetn)
      ev_eot |=> rx_status[drc_pkg::P_EOT_ERR] ##1 (rx_status[drc_pkg::P_EOT_ERR] || $past(rd_status)))
      else $error("end error not flagged");
   a_eot_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_status && !ev_eot) |=> !rx_status[drc_pkg::P_EOT_ERR])
      else $error("end error not cleared by read");
   a_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_primary[7] && !cfg_second[2] && !err_cfg[7])
      else $error("reserved bit set");

   a_eot_skip: assert property (@(posedge hclk) disable iff (!hresetn)
      (link_edge && lk.eot && cfg_second[drc_pkg::P_NO_EOTPKT] && !rx_status[drc_pkg::P_EOT_ERR])
      |=> !rx_status[drc_pkg::P_EOT_ERR])
      else $error("end error raised in skip mode");
   a_filter_off: assert property (@(posedge hclk) disable iff (!hresetn)
      pkt_drop |-> !$past(cfg_second[drc_pkg::P_NO_FILTER]))
      else $error("packet dropped with filter off");
   a_blank_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
      (link_edge && lk.crc_err && lk.blank_pkt && cfg_second[drc_pkg::P_BLANK_CRC]
       && !int_status[drc_pkg::I_CRC]) |=> !int_status[drc_pkg::I_CRC])
      else $error("blank packet checksum reported");
   a_vs_level: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_primary[drc_pkg::P_SYNC_REGEN] |=> vsync_out == ($past(lk.vs) ^ $past(cfg_second[drc_pkg::P_VS_POL])))
      else $error("vertical sync level wrong");
   a_err_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_second[drc_pkg::P_HOLD_ERR] |=> error_out == $past(ev_sum))
      else $error("pulsed error indication wrong");
endmodule // drc_regs
`default_nettype wire

// *** test/drc_link_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Far-side protocol logic: one event set per rising edge of the link clock
module drc_link_model (
   input  wire logic                  hclk,
   output logic                       link_clk,
   output drc_pkg::drc_link_type      link_in
);
   // Link clock stands still low between frames
   initial begin
      link_clk = 1'b0;
      link_in  = '0;
   end
   // Fields settle half a link period before the rise and stay after it,
   // because the block samples the event fields only at detected rising edges
   task automatic send(input drc_pkg::drc_link_type v);
      link_in <= v;
      repeat (6) @(posedge hclk);
      link_clk <= 1'b1;
      repeat (6) @(posedge hclk);
      link_clk <= 1'b0;
      repeat (6) @(posedge hclk);
   endtask
endmodule // drc_link_model
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
   // Byte addresses, four times the register index
   localparam logic [31:0] A_LS = 32'h54, A_P = 32'h80, A_S = 32'h84, A_E = 32'h8C;
   localparam logic [31:0] A_ST = 32'hA0, A_IS = 32'hC0, A_IM = 32'hC4;
   logic        hclk = 1'b0;      // Bus clock
   logic        hresetn = 1'b0;   // Reset, active low
   logic        hsel = 1'b0;      // Slave select
   logic [31:0] haddr = '0;       // Address phase
   logic [1:0]  htrans = '0;      // Transfer kind
   logic        hwrite = 1'b0;    // Direction
   logic [31:0] hwdata = '0;      // Write data
   logic [15:0] pixel_in = '0;    // Narrow pixel
   wire  logic  hready;           // Bus ready, the one slave's answer
   logic        hreadyout, hresp, link_clk, vsync_out, hsync_out, error_out;
   logic        recover_req, cmd_accept, pkt_pass, pkt_drop, irq;
   logic [31:0] hrdata, rv;       // Read data and last value taken
   logic [23:0] pixel_out;        // Widened pixel
   drc_pkg::drc_link_type link_in;
   int errors = 0, checked = 0;
   int n_rec = 0, n_cmd = 0, n_pass = 0, n_drop = 0, n_err = 0;  // Pulse cycle counts
   assign hready = hreadyout;
   always #2 hclk = ~hclk;
   // Count high cycles of each pulse output
   always @(posedge hclk) begin
      n_rec  += int'(recover_req === 1'b1);
      n_cmd  += int'(cmd_accept === 1'b1);
      n_pass += int'(pkt_pass === 1'b1);
      n_drop += int'(pkt_drop === 1'b1);
      n_err  += int'(error_out === 1'b1);
   end
   drc_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .link_clk(link_clk), .link_in(link_in), .pixel_in(pixel_in),
      .pixel_out(pixel_out), .vsync_out(vsync_out), .hsync_out(hsync_out), .error_out(error_out),
      .recover_req(recover_req), .cmd_accept(cmd_accept), .pkt_pass(pkt_pass),
      .pkt_drop(pkt_drop), .irq(irq));
   drc_link_model m (.hclk(hclk), .link_clk(link_clk), .link_in(link_in));
   // One single-word transfer; holds each phase until hready is seen high
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= drc_pkg::HTRANS_NONSEQ;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rv = hrdata;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Register read compared against a worked-out value
   task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, e, rv);
      chk("hresp", 32'h0, hresp);
   endtask
   // Reset values, reserved bits, read-only snapshot, unmapped place
   task automatic t_regs;
      rc("cfg_p", A_P, 32'h7F);
      rc("cfg_s", A_S, 32'h00);
      rc("err_cfg", A_E, 32'h7F);
      rc("lane", A_LS, 32'h00);
      xfer(1'b1, A_P, 32'hFF);
      rc("cfg_p_rsv", A_P, 32'h7F);
      xfer(1'b1, A_S, 32'hFF);
      rc("cfg_s_rsv", A_S, 32'hFB);
      xfer(1'b1, A_S, 32'h00);
      xfer(1'b1, A_LS, 32'hFF);
      rc("lane_ro", A_LS, 32'h00);
      rc("unmapped", 32'h100, 32'h00);
      $display("test regs done");
   endtask
   // Sync error: snapshot, sticky status, interrupt, recovery pulse
   task automatic t_sync;
      drc_pkg::drc_link_type v;
      v = '0;
      v.sync_err = 1'b1;
      v.lane_sync = 4'hA;
      xfer(1'b1, A_IM, 32'h0F);
      m.send(v);
      chk("irq_set", 32'h1, irq);
      rc("lane", A_LS, 32'h0A);
      rc("int_st", A_IS, 32'h01);
      rc("rx_st", A_ST, 32'h01);
      rc("rx_st_rc", A_ST, 32'h00);
      chk("recover", 32'h1, n_rec);
      chk("err_pulse", 32'h1, n_err);
      xfer(1'b1, A_IS, 32'h0F);
      rc("int_clr", A_IS, 32'h00);
      chk("irq_clr", 32'h0, irq);
      xfer(1'b1, A_P, 32'h3F);
      v.lane_sync = 4'h5;
      m.send(v);
      rc("lane2", A_LS, 32'h05);
      chk("no_recover", 32'h1, n_rec);
      rc("rx_st2", A_ST, 32'h01);
      xfer(1'b1, A_P, 32'h7F);
      xfer(1'b1, A_IS, 32'h0F);
      $display("test sync done");
   endtask
   // Disabled channel flags, is gated onto the summary and still passes
   task automatic t_vc;
      drc_pkg::drc_link_type v;
      v = '0;
      v.pkt_start = 1'b1;
      n_pass = 0;
      xfer(1'b1, A_P, 32'h7E);
      m.send(v);
      chk("pass", 32'h1, n_pass);
      rc("ivc", A_IS, 32'h02);
      rc("sum_on", A_ST, 32'h01);
      xfer(1'b1, A_IS, 32'h0F);
      xfer(1'b1, A_E, 32'h77);
      rc("err_cfg", A_E, 32'h77);
      m.send(v);
      rc("sum_off", A_ST, 32'h00);
      rc("ivc2", A_IS, 32'h02);
      xfer(1'b1, A_IS, 32'h0F);
      v.pkt_vc = 2'h1;
      m.send(v);
      rc("vc_ok", A_IS, 32'h00);
      chk("pass3", 32'h3, n_pass);
      xfer(1'b1, A_E, 32'h7F);
      xfer(1'b1, A_P, 32'h7F);
      $display("test vc done");
   endtask
   // Missing end packet, with and without the skip bit
   task automatic t_eot;
      drc_pkg::drc_link_type v;
      v = '0;
      v.eot = 1'b1;
      m.send(v);
      rc("eot_err", A_ST, 32'h04);
      rc("eot_rc", A_ST, 32'h00);
      v.eot_pkt = 1'b1;
      m.send(v);
      rc("eot_pkt", A_ST, 32'h00);
      xfer(1'b1, A_S, 32'h01);
      v.eot_pkt = 1'b0;
      m.send(v);
      rc("eot_skip", A_ST, 32'h00);
      xfer(1'b1, A_S, 32'h00);
      xfer(1'b1, A_IS, 32'h0F);
      $display("test eot done");
   endtask
   // Commands, then word-count filter
   task automatic t_cmd;
      drc_pkg::drc_link_type v;
      v = '0;
      v.hs_cmd = 1'b1;
      n_cmd = 0;
      m.send(v);
      chk("cmd_ign", 32'h0, n_cmd);
      xfer(1'b1, A_P, 32'h5F);
      m.send(v);
      chk("cmd_acc", 32'h1, n_cmd);
      xfer(1'b1, A_P, 32'h7F);
      v = '0;
      v.pkt_start = 1'b1;
      v.pkt_vc = 2'h1;
      v.wc_bad = 1'b1;
      n_drop = 0;
      m.send(v);
      chk("drop", 32'h1, n_drop);
      xfer(1'b1, A_S, 32'h02);
      m.send(v);
      chk("no_filt", 32'h1, n_drop);
      xfer(1'b1, A_S, 32'h00);
      $display("test cmd done");
   endtask
   // Grayscale replication on and off
   task automatic t_pix;
      pixel_in <= 16'h8410;
      repeat (2) @(posedge hclk);
      chk("gray", 32'h848284, pixel_out);
      xfer(1'b1, A_S, 32'h80);
      repeat (2) @(posedge hclk);
      chk("no_gray", 32'h808080, pixel_out);
      xfer(1'b1, A_S, 32'h00);
      $display("test pix done");
   endtask
   // Sync polarity and regeneration
   task automatic t_pol;
      drc_pkg::drc_link_type v;
      v = '0;
      v.vs = 1'b1;
      m.send(v);
      chk("vs_hi", 32'h1, vsync_out);
      chk("hs_lo", 32'h0, hsync_out);
      xfer(1'b1, A_S, 32'h60);
      m.send(v);
      chk("vs_inv", 32'h0, vsync_out);
      chk("hs_inv", 32'h1, hsync_out);
      xfer(1'b1, A_P, 32'h6F);
      m.send(v);
      chk("no_regen", 32'h0, {vsync_out, hsync_out});
      xfer(1'b1, A_P, 32'h7F);
      xfer(1'b1, A_S, 32'h00);
      $display("test pol done");
   endtask
   // Held error level, then checksum on blank packets
   task automatic t_hold;
      drc_pkg::drc_link_type v;
      v = '0;
      v.sync_err = 1'b1;
      xfer(1'b1, A_S, 32'h10);
      m.send(v);
      repeat (10) @(posedge hclk);
      chk("hold_lvl", 32'h1, error_out);
      rc("hold_st", A_ST, 32'h01);
      repeat (2) @(posedge hclk);
      chk("hold_clr", 32'h0, error_out);
      xfer(1'b1, A_S, 32'h00);
      xfer(1'b1, A_IS, 32'h0F);
      v = '0;
      v.crc_err = 1'b1;
      v.blank_pkt = 1'b1;
      m.send(v);
      rc("crc_blank", A_IS, 32'h08);
      xfer(1'b1, A_IS, 32'h0F);
      xfer(1'b1, A_S, 32'h08);
      m.send(v);
      rc("crc_off", A_IS, 32'h00);
      $display("test hold done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Watchdog: the whole sequence needs well under this span
   initial begin
      #200000;
      errors++;
      $display("FAIL watchdog expected done seen hang");
      report_and_stop();
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_sync();
      t_vc();
      t_eot();
      t_cmd();
      t_pix();
      t_pol();
      t_hold();
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
